// [verilog/rqf_rx_queue.sv]
`timescale 1ns/1ps
`default_nettype none
module rqf_rx_queue
  import rqf_pkg::*;
#(
  parameter int QUEUE_BYTES = QUEUE_BYTES_DEF
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // receive byte stream from the mac
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  input  wire logic [1:0]  rx_src_port,
  input  wire logic        rx_crc_err,
  input  wire logic        rx_runt,
  // queue state
  output logic             frame_valid_flag
);
  localparam int AW = $clog2(QUEUE_BYTES);
  localparam logic [AW:0] SPACE_LIM = (AW+1)'(QUEUE_BYTES - MAX_SLOT - 2);
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  rqf_state_e        st_q;
  logic [2:0]        ctrl_q;
  logic [AW-1:0]     head_q;
  logic [AW-1:0]     commit_q;
  logic [AW-1:0]     rd_off_q;
  logic [AW-1:0]     stride_q;
  logic [CNT_W-1:0]  tot_q;
  logic [1:0]        hdr_idx_q;
  logic [31:0]       hdr_q;
  logic [1:0]        port_q;
  logic              crc_q;
  logic              runt_q;
  logic [31:0]       reg_rdata_q;

  logic              pass_bad;
  logic              strip;
  logic              rx_en;
  logic              head_valid;
  logic              space_ok;
  logic              start_ok;
  logic              take;
  logic              store;
  logic [AW:0]       used;
  logic              bcast;
  logic              mcast;
  logic              ucast;
  logic              etype;
  logic              oversize;
  logic              bad;
  logic              port_ok;
  logic              keep;
  logic [CNT_W-1:0]  len;
  logic [15:0]       new_stat;
  logic [15:0]       head_stat;
  logic [15:0]       head_cnt;
  logic [CNT_W-1:0]  head_len;
  logic              data_rd;
  logic              rel_wr;

  rqf_mem_if #(.AW(AW)) qm ();

  // bytes a frame occupies: header plus data, padded to a word
  function automatic logic [AW-1:0] slot_bytes(input logic [CNT_W-1:0] n);
    logic [CNT_W:0] even;
    even = {1'b0, n} + (CNT_W+1)'(n[0]);
    return AW'(OFS_DATA) + AW'(even);
  endfunction

  assign pass_bad = ctrl_q[CTRL_PASS_BAD];
  assign strip    = ctrl_q[CTRL_STRIP];
  assign rx_en    = ctrl_q[CTRL_RX_EN];

  // room check reserves a worst case frame before the first byte
  assign used       = {1'b0, AW'(commit_q - head_q)};
  assign space_ok   = (used <= SPACE_LIM);
  assign start_ok   = rx_en & space_ok;
  assign head_valid = (commit_q != head_q);

  // each of the first 1916 bytes goes in verbatim, addresses and type field alike
  assign take  = rx_valid & (((st_q == RQF_IDLE) & start_ok) |
                             (st_q == RQF_RECV));
  assign store = take & (tot_q < CNT_W'(MAX_DATA));

  // receive sequencing
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= RQF_IDLE;
    end else begin
      case (st_q)
        RQF_IDLE: begin
          if (rx_valid && start_ok) begin
            st_q <= rx_last ? RQF_EVAL : RQF_RECV;
          end else if (rx_valid && !rx_last) begin
            st_q <= RQF_DROP;
          end
        end
        RQF_RECV: begin
          if (rx_valid && rx_last) begin
            st_q <= RQF_EVAL;
          end
        end
        RQF_DROP: begin
          if (rx_valid && rx_last) begin
            st_q <= RQF_IDLE;
          end
        end
        RQF_EVAL: begin
          st_q <= keep ? RQF_HDR : RQF_IDLE;
        end
        RQF_HDR: begin
          if (hdr_idx_q == 2'h3) begin
            st_q <= RQF_IDLE;
          end
        end
        default: begin
          st_q <= RQF_IDLE;
        end
      endcase
    end
  end

  // received byte count, saturating so long frames still flag
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tot_q <= '0;
    end else if (st_q == RQF_IDLE && !take) begin
      tot_q <= '0;
    end else if (take && tot_q != CNT_MAX) begin
      tot_q <= (st_q == RQF_IDLE) ? CNT_W'(1) : tot_q + CNT_W'(1);
    end else if (take) begin
      tot_q <= tot_q;
    end
  end

  // end of frame flags from the mac
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      port_q <= 2'h0;
      crc_q  <= 1'b0;
      runt_q <= 1'b0;
    end else if (take && rx_last) begin
      port_q <= rx_src_port;
      crc_q  <= rx_crc_err;
      runt_q <= rx_runt;
    end
  end

  rqf_classify u_classify (
    .mclk     (mclk),
    .resetn   (resetn),
    .byte_en  (take),
    .byte_idx ((st_q == RQF_IDLE) ? '0 : tot_q),
    .byte_val (rx_data),
    .bcast    (bcast),
    .mcast    (mcast),
    .ucast    (ucast),
    .etype    (etype)
  );

  // oversize is a flag only, the stored data is not cut for it
  assign oversize = (tot_q > CNT_W'(MAX_LEN));
  assign bad      = oversize | runt_q | crc_q;
  assign port_ok  = (port_q == PORT_ONE) | (port_q == PORT_TWO);
  assign keep     = port_ok & (~bad | pass_bad);

  // stored length: fcs left out of the count when stripping
  always_comb begin
    len = tot_q;
    if (strip) begin
      len = (tot_q >= CNT_W'(FCS_BYTES)) ?
            tot_q - CNT_W'(FCS_BYTES) : '0;
    end
    if (len > CNT_W'(MAX_DATA)) begin
      len = CNT_W'(MAX_DATA);
    end
  end

  // status word, reserved bits forced low
  always_comb begin
    new_stat = 16'h0000;
    new_stat[BIT_VALID] = 1'b1;
    new_stat[BIT_PORT +: 2] = port_q;
    new_stat[BIT_BCAST] = bcast;
    new_stat[BIT_MCAST] = mcast;
    new_stat[BIT_UCAST] = ucast;
    new_stat[BIT_ETYPE] = etype;
    new_stat[BIT_OVER]  = oversize;
    new_stat[BIT_RUNT]  = runt_q;
    new_stat[BIT_FCS]   = crc_q;
  end

  // header latched once, then written a byte per cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hdr_q     <= 32'h0000_0000;
      stride_q  <= '0;
      hdr_idx_q <= 2'h0;
    end else if (st_q == RQF_EVAL) begin
      hdr_q     <= {(16-CNT_W)'(0), len, new_stat};
      stride_q  <= slot_bytes(len);
      hdr_idx_q <= 2'h0;
    end else if (st_q == RQF_HDR) begin
      hdr_idx_q <= hdr_idx_q + 2'h1;
    end
  end

  // write port: data after the header slot, header last
  assign qm.we    = store | (st_q == RQF_HDR);
  assign qm.waddr = (st_q == RQF_HDR) ?
                    commit_q + AW'(OFS_STATUS) + AW'(hdr_idx_q) :
                    commit_q + AW'(OFS_DATA) +
                    ((st_q == RQF_IDLE) ? '0 : AW'(tot_q));
  assign qm.wdata = (st_q == RQF_HDR) ? hdr_q[8*hdr_idx_q +: 8] : rx_data;

  // frame becomes visible only after its header is complete
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      commit_q <= '0;
    end else if (st_q == RQF_HDR && hdr_idx_q == 2'h3) begin
      commit_q <= commit_q + stride_q;
    end
  end

  // head frame view for the host
  assign qm.ra_stat = head_q + AW'(OFS_STATUS);
  assign qm.ra_cnt  = head_q + AW'(OFS_COUNT);
  assign qm.ra_dat  = head_q + AW'(OFS_DATA) + rd_off_q;
  assign head_stat  = head_valid ? qm.rd_stat : 16'h0000;
  assign head_len   = qm.rd_cnt[CNT_W-1:0];
  assign head_cnt   = head_valid ?
                      {(16-CNT_W)'(0), head_len} : 16'h0000;

  rqf_qmem #(.DEPTH(QUEUE_BYTES), .AW(AW)) u_qmem (
    .mclk (mclk),
    .m    (qm)
  );

  assign data_rd = reg_rd & (reg_addr == REG_DATA) & head_valid &
                   (rd_off_q < AW'(head_len));
  assign rel_wr  = reg_wr & (reg_addr == REG_REL) & reg_wdata[0] &
                   head_valid;

  // release pops the head frame, ignored when none is pending
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      head_q <= '0;
    end else if (rel_wr) begin
      head_q <= head_q + slot_bytes(head_len);
    end
  end

  // data window walks the head frame a word per read
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      rd_off_q <= '0;
    end else if (rel_wr) begin
      rd_off_q <= '0;
    end else if (data_rd) begin
      rd_off_q <= rd_off_q + AW'(2);
    end
  end

  // control register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_q <= reg_wdata[2:0];
    end
  end

  // read data stands for one cycle after the strobe
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:  reg_rdata_q <= {29'h0, ctrl_q};
        REG_STAT:  reg_rdata_q <= {16'h0000, head_stat};
        REG_COUNT: reg_rdata_q <= {16'h0000, head_cnt};
        REG_DATA:  reg_rdata_q <= data_rd ?
                                  {16'h0000, qm.rd_dat} : 32'h0000_0000;
        default:   reg_rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata        = reg_rdata_q;
  assign frame_valid_flag = head_valid;
endmodule
`default_nettype wire

// [verilog/rqf_pkg.sv]
// How it works
// - length/type word stored as plain data
// - status at 0, count at 2, data from 4
// - at most 1916 data bytes stored
// - fcs dropped from count when stripping
// - status always describes the head frame
// - valid bit only for complete head frame
// - bits 9-8 ingress port, 01 or 10
// - bit 7 marks broadcast destination
// - bit 6 marks multicast, broadcast included
// - bit 5 marks unicast destination
// - bit 3 set when type above 1500
// - bit 2 oversize above 1518, no truncation
// - bit 1 marks runt or collision frame
// - bit 0 marks fcs compare failure
// - bad frames kept only with pass-bad set
// - count in bits 10-0, rest reserved
package rqf_pkg;
  localparam int QUEUE_BYTES_DEF = 4096;
  // frame layout inside the queue
  localparam int OFS_STATUS = 0;
  localparam int OFS_COUNT  = 2;
  localparam int OFS_DATA   = 4;
  localparam int MAX_DATA   = 1916;
  localparam int MAX_LEN    = 1518;
  localparam int TYPE_MIN   = 1500;
  localparam int FCS_BYTES  = 4;
  localparam int MAX_SLOT   = OFS_DATA + MAX_DATA;
  localparam int CNT_W      = 11;
  localparam int TYPE_HI_IDX = 12;
  localparam int TYPE_LO_IDX = 13;
  localparam int DA_LAST_IDX = 5;
  // status word bits
  localparam int BIT_VALID = 15;
  localparam int BIT_PORT  = 8;
  localparam int BIT_BCAST = 7;
  localparam int BIT_MCAST = 6;
  localparam int BIT_UCAST = 5;
  localparam int BIT_ETYPE = 3;
  localparam int BIT_OVER  = 2;
  localparam int BIT_RUNT  = 1;
  localparam int BIT_FCS   = 0;
  localparam logic [1:0] PORT_ONE = 2'h1;
  localparam logic [1:0] PORT_TWO = 2'h2;
  // register map, byte addresses
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_STAT  = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_DATA  = 8'h0C;
  localparam logic [7:0] REG_REL   = 8'h10;
  localparam int CTRL_PASS_BAD = 0;
  localparam int CTRL_STRIP    = 1;
  localparam int CTRL_RX_EN    = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;
  typedef enum logic [4:0] {
    RQF_IDLE = 5'h01,
    RQF_RECV = 5'h02,
    RQF_DROP = 5'h04,
    RQF_EVAL = 5'h08,
    RQF_HDR  = 5'h10
  } rqf_state_e;
endpackage

// [verilog/rqf_mem_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface rqf_mem_if #(parameter int AW = 12);
  logic          we;
  logic [AW-1:0] waddr;
  logic [7:0]    wdata;
  logic [AW-1:0] ra_stat;
  logic [AW-1:0] ra_cnt;
  logic [AW-1:0] ra_dat;
  logic [15:0]   rd_stat;
  logic [15:0]   rd_cnt;
  logic [15:0]   rd_dat;
  modport mem  (input we, waddr, wdata, ra_stat, ra_cnt, ra_dat,
                output rd_stat, rd_cnt, rd_dat);
  modport user (output we, waddr, wdata, ra_stat, ra_cnt, ra_dat,
                input rd_stat, rd_cnt, rd_dat);
endinterface
`default_nettype wire

// [verilog/rqf_qmem.sv]
`timescale 1ns/1ps
`default_nettype none
module rqf_qmem
  import rqf_pkg::*;
#(
  parameter int DEPTH = QUEUE_BYTES_DEF,
  parameter int AW    = 12
) (
  // clock
  input wire logic mclk,
  // queue port
  rqf_mem_if.mem   m
);
  logic [7:0] mem_q [DEPTH];

  // word read, first byte in the low half
  function automatic logic [15:0] word_at(input logic [AW-1:0] a);
    return {mem_q[{a[AW-1:1], 1'b1}], mem_q[{a[AW-1:1], 1'b0}]};
  endfunction

  // payload storage needs no reset, the header marks what is live
  always_ff @(posedge mclk) begin
    if (m.we) begin
      mem_q[m.waddr] <= m.wdata;
    end
  end

  assign m.rd_stat = word_at(m.ra_stat);
  assign m.rd_cnt  = word_at(m.ra_cnt);
  assign m.rd_dat  = word_at(m.ra_dat);
endmodule
`default_nettype wire

// [verilog/rqf_classify.sv]
`timescale 1ns/1ps
`default_nettype none
module rqf_classify
  import rqf_pkg::*;
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             resetn,
  // stored byte stream
  input  wire logic             byte_en,
  input  wire logic [CNT_W-1:0] byte_idx,
  input  wire logic [7:0]       byte_val,
  // destination and type flags
  output logic                  bcast,
  output logic                  mcast,
  output logic                  ucast,
  output logic                  etype
);
  logic [7:0] type_hi_q;

  // destination class from the first six bytes
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bcast <= 1'b0;
      mcast <= 1'b0;
    end else if (byte_en && byte_idx == '0) begin
      bcast <= (byte_val == 8'hFF);
      mcast <= byte_val[0];
    end else if (byte_en && byte_idx <= CNT_W'(DA_LAST_IDX)) begin
      bcast <= bcast & (byte_val == 8'hFF);
    end
  end

  // group bit clear means a single station
  assign ucast = ~mcast;

  // type field is big endian, bytes 12 and 13
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      type_hi_q <= 8'h00;
      etype     <= 1'b0;
    end else if (byte_en && byte_idx == '0) begin
      etype <= 1'b0;
    end else if (byte_en && byte_idx == CNT_W'(TYPE_HI_IDX)) begin
      type_hi_q <= byte_val;
    end else if (byte_en && byte_idx == CNT_W'(TYPE_LO_IDX)) begin
      etype <= {type_hi_q, byte_val} > 16'(TYPE_MIN);
    end
  end
endmodule
`default_nettype wire

// [bench/rqf_rx_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module rqf_rx_asserts
  import rqf_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // stream and state
  input wire logic        rx_valid,
  input wire logic        rx_last,
  input wire logic        frame_valid_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic rd_st;
  logic rd_ct;
  // which word the answer of this cycle belongs to
  always_ff @(posedge mclk) begin
    rd_st <= reg_rd && (reg_addr == REG_STAT);
    rd_ct <= reg_rd && (reg_addr == REG_COUNT);
  end
  idle_rdata_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer");
  stat_resv_a: assert property (rd_st |-> reg_rdata[31:16] == 16'h0
    && reg_rdata[14:10] == 5'h0 && !reg_rdata[4])
    else $error("reserved status bits set");
  stat_valid_a: assert property (rd_st |->
    reg_rdata[15] == $past(frame_valid_flag))
    else $error("valid bit differs from head state");
  empty_stat_a: assert property (rd_st && !$past(frame_valid_flag)
    |-> reg_rdata == 32'h0) else $error("status of empty queue not zero");
  port_code_a: assert property (rd_st && reg_rdata[15] |->
    reg_rdata[9:8] == PORT_ONE || reg_rdata[9:8] == PORT_TWO)
    else $error("bad ingress port code");
  bcast_mcast_a: assert property (rd_st && reg_rdata[7] |-> reg_rdata[6])
    else $error("broadcast without multicast");
  ucast_excl_a: assert property (rd_st && reg_rdata[15] |->
    reg_rdata[5] != reg_rdata[6]) else $error("unicast and multicast clash");
  count_field_a: assert property (rd_ct |-> reg_rdata[31:11] == 21'h0
    && reg_rdata[10:0] <= MAX_DATA) else $error("count word out of range");
  commit_lat_a: assert property (rx_valid && rx_last && !frame_valid_flag
    |=> !frame_valid_flag [*5]) else $error("frame valid too early");
  hold_head_a: assert property (frame_valid_flag &&
    !(reg_wr && reg_addr == REG_REL) |=> frame_valid_flag)
    else $error("head frame lost without release");
  // main scenarios
  cover property (rd_st && reg_rdata[15]);
  cover property (rd_st && reg_rdata[7]);
  cover property (rd_st && reg_rdata[0]);
endmodule
bind rqf_rx_queue rqf_rx_asserts u_chk (.mclk(mclk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_last(rx_last),
  .frame_valid_flag(frame_valid_flag));
`default_nettype wire

// [bench/rqf_mac_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rqf_mac_model (
  // clock
  input  wire logic mclk,
  // byte stream to the queue
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       rx_last,
  output logic [1:0] rx_src_port,
  output logic       rx_crc_err,
  output logic       rx_runt
);
  // byte i of a frame: dst six times, source, type, then payload
  function automatic logic [7:0] bval(int i, logic [7:0] dst,
                                      logic [15:0] typ);
    if (i < 6) return dst;
    if (i < 12) return 8'h20 + i[7:0];
    if (i == 12) return typ[15:8];
    if (i == 13) return typ[7:0];
    return i[7:0];
  endfunction
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    rx_last = 1'b0;
    rx_src_port = 2'h0;
    rx_crc_err = 1'b0;
    rx_runt = 1'b0;
  end
  // flags only hold meaning with the last byte, so invert them elsewhere
  // callers always pass a correct, nonzero byte count
  task automatic send(int len, logic [7:0] dst, logic [15:0] typ,
                      logic [1:0] port, logic crc, logic runt);
    for (int i = 0; i < len; i++) begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_data <= bval(i, dst, typ);
      rx_last <= (i == len - 1);
      rx_src_port <= (i == len - 1) ? port : ~port;
      rx_crc_err <= (i == len - 1) ? crc : ~crc;
      rx_runt <= (i == len - 1) ? runt : ~runt;
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~rx_data;
    rx_crc_err <= ~crc;
    rx_runt <= ~runt;
  endtask
endmodule
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rqf_pkg::*;
  logic        mclk;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        rx_valid;
  logic [7:0]  rx_data;
  logic        rx_last;
  logic [1:0]  rx_src_port;
  logic        rx_crc_err;
  logic        rx_runt;
  logic        frame_valid_flag;
  int          fails;
  int          cmp_count;
  rqf_rx_queue u_rqf_rx_queue (.mclk(mclk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_src_port(rx_src_port),
    .rx_crc_err(rx_crc_err), .rx_runt(rx_runt),
    .frame_valid_flag(frame_valid_flag));
  rqf_mac_model u_mac (.mclk(mclk), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_src_port(rx_src_port),
    .rx_crc_err(rx_crc_err), .rx_runt(rx_runt));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // answer stands only in the cycle after the read edge
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(exp, d);
  endtask
  // one frame through the queue; exp_st zero means it must be dropped
  task rx_chk(input logic [2:0] ctrl, input int len, input logic [7:0] dst,
              input logic [15:0] typ, input logic [1:0] port,
              input logic crc, input logic runt,
              input logic [31:0] exp_st, input logic [31:0] exp_cnt);
    int n;
    wr(REG_CTRL, {29'h0, ctrl});
    u_mac.send(len, dst, typ, port, crc, runt);
    n = 0;
    while (frame_valid_flag !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    rdc(REG_STAT, exp_st);
    if (exp_st != 32'h0) begin
      rdc(REG_COUNT, exp_cnt);
      for (int k = 0; k < 7; k++)
        rdc(REG_DATA, {16'h0, u_mac.bval(2 * k + 1, dst, typ),
                       u_mac.bval(2 * k, dst, typ)});
      wr(REG_REL, 32'h1);
      @(negedge mclk);
      chk(32'h0, {31'h0, frame_valid_flag});
    end
  endtask
  task t_reset();
    rdc(REG_CTRL, {29'h0, CTRL_RESET});
    rdc(REG_STAT, 32'h0);
    rdc(REG_COUNT, 32'h0);
    rdc(8'h14, 32'h0);
    $display("test reset done");
  endtask
  task t_class();
    rx_chk(3'h4, 64, 8'h02, 16'h0800, 2'h1, 0, 0, 32'h8128, 64);
    rx_chk(3'h4, 64, 8'hFF, 16'h0040, 2'h2, 0, 0, 32'h82C0, 64);
    rx_chk(3'h4, 64, 8'h01, 16'h05DC, 2'h1, 0, 0, 32'h8140, 64);
    rx_chk(3'h4, 64, 8'h00, 16'h05DD, 2'h2, 0, 0, 32'h8228, 64);
    $display("test class done");
  endtask
  task t_bad();
    rx_chk(3'h5, 64, 8'h02, 16'h0040, 2'h1, 1, 0, 32'h8121, 64);
    rx_chk(3'h5, 64, 8'h02, 16'h0040, 2'h2, 0, 1, 32'h8222, 64);
    rx_chk(3'h4, 64, 8'h02, 16'h0040, 2'h1, 1, 0, 32'h0, 0);
    rx_chk(3'h4, 64, 8'h02, 16'h0040, 2'h1, 0, 1, 32'h0, 0);
    rx_chk(3'h4, 64, 8'h02, 16'h0040, 2'h3, 0, 0, 32'h0, 0);
    rx_chk(3'h0, 64, 8'h02, 16'h0040, 2'h1, 0, 0, 32'h0, 0);
    $display("test bad done");
  endtask
  task t_len();
    rx_chk(3'h6, 64, 8'h02, 16'h0040, 2'h1, 0, 0, 32'h8120, 60);
    rx_chk(3'h4, 1518, 8'h02, 16'h0040, 2'h1, 0, 0, 32'h8120, 1518);
    rx_chk(3'h5, 1519, 8'h02, 16'h0040, 2'h1, 0, 0, 32'h8124, 1519);
    rx_chk(3'h4, 1519, 8'h02, 16'h0040, 2'h1, 0, 0, 32'h0, 0);
    rx_chk(3'h5, 2000, 8'h02, 16'h0040, 2'h1, 0, 0, 32'h8124, 1916);
    $display("test length done");
  endtask
  // watchdog well beyond the roughly 7700 cycles of traffic
  initial begin
    repeat (40000) @(posedge mclk);
    fails++;
    conclude();
  end
  initial begin
    fails = 0;
    cmp_count = 0;
    resetn = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_class();
    t_bad();
    t_len();
    conclude();
  end
endmodule
`default_nettype wire
